// >>> verilog/l2m_params.svh
`ifndef L2M_PARAMS_SVH
`define L2M_PARAMS_SVH
`define L2M_OFS_SYNC 12'h730
`define L2M_OFS_INV_LINE 12'h770
`define L2M_OFS_INV_WAYS 12'h77C
`define L2M_OFS_CLEAN_LINE 12'h7B0
`define L2M_OFS_CLEAN_SETWAY 12'h7B8
`define L2M_OFS_CLEAN_WAYS 12'h7BC
`define L2M_OFS_FLUSH_LINE 12'h7F0
`define L2M_OFS_FLUSH_SETWAY 12'h7F8
`define L2M_OFS_FLUSH_WAYS 12'h7FC
`define L2M_WAYS 16
`define L2M_SETS 8
`define L2M_LAST_INDEX 3'h7
`define L2M_WAY_MSB 31
`define L2M_WAY_LSB 28
`define L2M_WAY8_MSB 30
`define L2M_INDEX_MSB 7
`define L2M_INDEX_LSB 5
`define L2M_TAG_LSB 8
`define L2M_TAG_W 24
`define L2M_MASK_MSB 15
`define L2M_MASK_8WAY 16'h00FF
`define L2M_MASK_16WAY 16'hFFFF
`define L2M_BUSY_BIT 0
`define L2M_RESET_MASK 16'h0000
`define L2M_RESET_DATA 32'h0000_0000
`define L2M_RESET_INDEX 3'h0
`define L2M_RESET_WAY 4'h0
`define L2M_RESET_TAG 24'h00_0000
`endif

// >>> verilog/l2m_pkg.sv
package l2m_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOOKUP = 2'h1,
    ST_WRBACK = 2'h3,
    ST_SYNC = 2'h2
  } mstate_t;
  typedef enum logic [1:0] {
    OP_INVAL = 2'h0,
    OP_CLEAN = 2'h1,
    OP_FLUSH = 2'h2
  } op_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_t;
endpackage : l2m_pkg

// >>> verilog/way_sweeper.sv
`timescale 1ns/1ps
`include "l2m_params.svh"
module way_sweeper
  import l2m_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [15:0] i_start_mask,
  input wire logic i_step_done,
  output logic o_busy,
  output logic [3:0] o_way,
  output logic [2:0] o_index,
  output logic [15:0] o_mask
);
  logic [15:0] mask;
  logic [2:0] index;

  function automatic logic [3:0] lowest_way(input logic [15:0] m);
    logic [3:0] w;
    w = `L2M_RESET_WAY;
    for (int i = `L2M_MASK_MSB; i >= 0; i--) begin
      if (m[i]) begin
        w = 4'(i);
      end
    end
    return w;
  endfunction : lowest_way

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mask <= `L2M_RESET_MASK;
      index <= `L2M_RESET_INDEX;
    end else if (i_start) begin
      mask <= i_start_mask;
      index <= `L2M_RESET_INDEX;
    end else if (i_step_done) begin
      if (index == `L2M_LAST_INDEX) begin
        mask[lowest_way(mask)] <= 1'b0;
        index <= `L2M_RESET_INDEX;
      end else begin
        index <= index + 3'h1;
      end
    end
  end

  assign o_mask = mask;
  assign o_busy = |mask;
  assign o_way = lowest_way(mask);
  assign o_index = index;

  chk_mask_never_grows: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_start |=> (o_mask & ~$past(o_mask)) == 16'h0000)
    else $error("way mask gained a bit without a start");
  chk_way_retired_last: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_step_done && !i_start && o_index == `L2M_LAST_INDEX |=> !o_mask[$past(o_way)])
    else $error("way bit not cleared after its last index");
endmodule : way_sweeper

// >>> verilog/l2_cache_maintenance_ops.sv
// Contract
// - Non-secure address ops touch only non-secure lines
// - Writing an operation register starts it
// - Way field bits 31:28, bit 31 reserved if 8-way
// - Line ops and sync stall slave ports
// - Atomic register read bit 0 shows background busy
// - Way op starts on every set mask bit
// - Way bit clears when that way finishes
// - Mask bits 15:8 reserved in 8-way mode
// - Writes during background get slave error
// - Targeted ways get no new allocations
// - No hazard check on background data
// - Sync drains store buffer, waits empty buffers
// - Invalidate line marks addressed line invalid
// - Invalidate ways drops lines without writeback
// - Clean line writes back dirty, keeps valid
// - Clean ways writes back dirty lines, keeps valid
// - Flush line writes back then invalidates
// - Flush ways writes back and invalidates, background
// - Security tag bit never changed by maintenance
// - Unlock-all-lines also runs in background
// - Secure set/way ops ignore security tag
// - Non-secure set/way ops skip secure lines
// - Secure address ops touch only secure lines
`timescale 1ns/1ps
`include "l2m_params.svh"
module l2_cache_maintenance_ops
  import l2m_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_reg_req,
  input wire logic i_reg_write,
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_secure,
  output logic o_reg_ack,
  output logic [1:0] o_reg_resp,
  output logic [31:0] o_reg_rdata,
  output logic o_stall,
  input wire logic i_sixteen_way,
  input wire logic i_unlock_all_busy,
  input wire logic i_fill_valid,
  input wire logic [2:0] i_fill_index,
  input wire logic [3:0] i_fill_way,
  input wire logic [23:0] i_fill_tag,
  input wire logic i_fill_ns,
  input wire logic i_fill_dirty,
  output logic o_wb_valid,
  output logic [31:0] o_wb_addr,
  input wire logic i_wb_ready,
  output logic o_drain_store_buffer,
  input wire logic i_store_buffer_empty,
  input wire logic i_line_read_buffer_empty,
  input wire logic i_line_fill_buffer_empty,
  input wire logic i_eviction_buffer_empty,
  output logic [15:0] o_alloc_lock,
  output logic o_bg_busy
);
  function automatic logic is_atomic(input logic [11:0] a);
    return a == `L2M_OFS_SYNC || a == `L2M_OFS_INV_LINE ||
      a == `L2M_OFS_CLEAN_LINE || a == `L2M_OFS_CLEAN_SETWAY ||
      a == `L2M_OFS_FLUSH_LINE || a == `L2M_OFS_FLUSH_SETWAY;
  endfunction : is_atomic

  function automatic logic is_way_reg(input logic [11:0] a);
    return a == `L2M_OFS_INV_WAYS || a == `L2M_OFS_CLEAN_WAYS ||
      a == `L2M_OFS_FLUSH_WAYS;
  endfunction : is_way_reg

  function automatic op_t op_of(input logic [11:0] a);
    op_t op;
    case (a)
      `L2M_OFS_INV_LINE, `L2M_OFS_INV_WAYS: op = OP_INVAL;
      `L2M_OFS_CLEAN_LINE, `L2M_OFS_CLEAN_SETWAY, `L2M_OFS_CLEAN_WAYS: op = OP_CLEAN;
      default: op = OP_FLUSH;
    endcase
    return op;
  endfunction : op_of

  // Tag store: valid, dirty, non-secure tag and address tag per line
  logic [`L2M_WAYS-1:0] valid_q [`L2M_SETS];
  logic [`L2M_WAYS-1:0] dirty_q [`L2M_SETS];
  logic [`L2M_WAYS-1:0] ns_q [`L2M_SETS];
  logic [`L2M_TAG_W-1:0] tag_q [`L2M_SETS][`L2M_WAYS];

  mstate_t state;
  op_t cur_op;
  op_t bg_op;
  logic cur_by_addr;
  logic cur_secure;
  logic cur_from_sweep;
  logic [3:0] cur_way;
  logic [2:0] cur_index;
  logic [23:0] cur_tag;
  logic bg_secure;

  logic [15:0] way_en;
  logic take;
  logic take_wr;
  logic bg_busy;
  logic sweep_go;
  logic sweep_start;
  logic [15:0] sweep_start_mask;
  logic sweep_step_done;
  logic sweep_busy;
  logic [3:0] sweep_way;
  logic [2:0] sweep_index;
  logic [15:0] sweep_mask;
  logic look_ok;
  logic look_dirty;
  logic [3:0] look_way;
  logic [3:0] tgt_way;
  logic need_wb;
  logic line_done;
  logic line_apply;
  logic sync_done;
  logic op_end;
  logic [3:0] wdata_way;
  logic [31:0] read_value;

  assign way_en = i_sixteen_way ? `L2M_MASK_16WAY : `L2M_MASK_8WAY;
  // An unlock-all sweep elsewhere counts as a background task here
  assign bg_busy = sweep_busy | i_unlock_all_busy;
  assign take = i_reg_req && state == ST_IDLE && !o_reg_ack;
  assign take_wr = take && i_reg_write;
  // Register requests win; the ack cycle always leaves the sweeper a slot
  assign sweep_go = state == ST_IDLE && sweep_busy && !take;
  assign sweep_start = take_wr && !bg_busy && is_way_reg(i_reg_addr);
  assign sweep_start_mask = i_reg_wdata[15:0] & way_en;
  assign wdata_way = i_sixteen_way ? i_reg_wdata[`L2M_WAY_MSB:`L2M_WAY_LSB] :
    {1'b0, i_reg_wdata[`L2M_WAY8_MSB:`L2M_WAY_LSB]};
  assign sync_done = i_store_buffer_empty && i_line_read_buffer_empty &&
    i_line_fill_buffer_empty && i_eviction_buffer_empty;

  always_comb begin
    look_way = cur_way;
    look_ok = 1'b0;
    if (cur_by_addr) begin
      for (int w = 0; w < `L2M_WAYS; w++) begin
        if (way_en[w] && valid_q[cur_index][w] && tag_q[cur_index][w] == cur_tag &&
            ns_q[cur_index][w] == !cur_secure) begin
          look_ok = 1'b1;
          look_way = 4'(w);
        end
      end
    end else begin
      look_ok = valid_q[cur_index][cur_way] &&
        (cur_secure || ns_q[cur_index][cur_way]);
    end
    look_dirty = dirty_q[cur_index][look_way];
  end

  assign need_wb = look_ok && look_dirty && cur_op != OP_INVAL;
  assign line_done = (state == ST_LOOKUP && !need_wb) || (state == ST_WRBACK && i_wb_ready);
  assign line_apply = line_done && (state == ST_WRBACK || look_ok);
  assign tgt_way = state == ST_LOOKUP ? look_way : cur_way;
  assign op_end = line_done || (state == ST_SYNC && sync_done);
  assign sweep_step_done = line_done && cur_from_sweep;

  always_comb begin
    read_value = `L2M_RESET_DATA;
    if (is_atomic(i_reg_addr)) begin
      read_value[`L2M_BUSY_BIT] = bg_busy;
    end else if (is_way_reg(i_reg_addr) && op_of(i_reg_addr) == bg_op) begin
      read_value[15:0] = sweep_mask;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      o_reg_ack <= 1'b0;
      o_reg_resp <= RESP_OKAY;
      o_reg_rdata <= `L2M_RESET_DATA;
      o_stall <= 1'b0;
      o_drain_store_buffer <= 1'b0;
      o_wb_valid <= 1'b0;
      o_wb_addr <= `L2M_RESET_DATA;
      cur_op <= OP_INVAL;
      cur_by_addr <= 1'b0;
      cur_secure <= 1'b0;
      cur_from_sweep <= 1'b0;
      cur_way <= `L2M_RESET_WAY;
      cur_index <= `L2M_RESET_INDEX;
      cur_tag <= `L2M_RESET_TAG;
    end else begin
      o_reg_ack <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            if (!i_reg_write) begin
              o_reg_ack <= 1'b1;
              o_reg_resp <= RESP_OKAY;
              o_reg_rdata <= read_value;
            end else if (bg_busy) begin
              o_reg_ack <= 1'b1;
              o_reg_resp <= RESP_SLVERR;
            end else if (is_atomic(i_reg_addr)) begin
              o_stall <= 1'b1;
              cur_op <= op_of(i_reg_addr);
              cur_secure <= i_reg_secure;
              cur_from_sweep <= 1'b0;
              // Low line bits, bit 0 included, never reach the lookup
              cur_index <= i_reg_wdata[`L2M_INDEX_MSB:`L2M_INDEX_LSB];
              cur_tag <= i_reg_wdata[31:`L2M_TAG_LSB];
              cur_way <= wdata_way;
              cur_by_addr <= i_reg_addr == `L2M_OFS_INV_LINE ||
                i_reg_addr == `L2M_OFS_CLEAN_LINE || i_reg_addr == `L2M_OFS_FLUSH_LINE;
              if (i_reg_addr == `L2M_OFS_SYNC) begin
                o_drain_store_buffer <= 1'b1;
                state <= ST_SYNC;
              end else begin
                state <= ST_LOOKUP;
              end
            end else begin
              o_reg_ack <= 1'b1;
              o_reg_resp <= RESP_OKAY;
            end
          end else if (sweep_go) begin
            cur_op <= bg_op;
            cur_secure <= bg_secure;
            cur_from_sweep <= 1'b1;
            cur_by_addr <= 1'b0;
            cur_way <= sweep_way;
            cur_index <= sweep_index;
            state <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          if (need_wb) begin
            o_wb_valid <= 1'b1;
            o_wb_addr <= {tag_q[cur_index][look_way], cur_index, 5'h00};
            cur_way <= look_way;
            cur_by_addr <= 1'b0;
            state <= ST_WRBACK;
          end
        end
        ST_WRBACK: begin
          if (i_wb_ready) begin
            o_wb_valid <= 1'b0;
          end
        end
        ST_SYNC: begin
          if (sync_done) begin
            o_drain_store_buffer <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (op_end) begin
        state <= ST_IDLE;
        if (!cur_from_sweep) begin
          o_stall <= 1'b0;
          o_reg_ack <= 1'b1;
          o_reg_resp <= RESP_OKAY;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bg_op <= OP_INVAL;
      bg_secure <= 1'b0;
    end else if (sweep_start) begin
      bg_op <= op_of(i_reg_addr);
      bg_secure <= i_reg_secure;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int s = 0; s < `L2M_SETS; s++) begin
        valid_q[s] <= `L2M_RESET_MASK;
        dirty_q[s] <= `L2M_RESET_MASK;
      end
    end else begin
      if (i_fill_valid) begin
        valid_q[i_fill_index][i_fill_way] <= 1'b1;
        dirty_q[i_fill_index][i_fill_way] <= i_fill_dirty;
      end
      if (line_apply) begin
        dirty_q[cur_index][tgt_way] <= 1'b0;
        if (cur_op != OP_CLEAN) begin
          valid_q[cur_index][tgt_way] <= 1'b0;
        end
      end
    end
  end

  // Only fills write these; maintenance leaves the security tag alone
  always_ff @(posedge i_mclk) begin
    if (i_fill_valid) begin
      tag_q[i_fill_index][i_fill_way] <= i_fill_tag;
      ns_q[i_fill_index][i_fill_way] <= i_fill_ns;
    end
  end

  // Hits still reach locked ways and nothing checks returned data, so
  // lines dirtied behind the sweep stay dirty after a clean completes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_alloc_lock <= `L2M_RESET_MASK;
      o_bg_busy <= 1'b0;
    end else begin
      o_alloc_lock <= sweep_mask;
      o_bg_busy <= bg_busy;
    end
  end

  way_sweeper u_sweeper (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(sweep_start),
    .i_start_mask(sweep_start_mask),
    .i_step_done(sweep_step_done),
    .o_busy(sweep_busy),
    .o_way(sweep_way),
    .o_index(sweep_index),
    .o_mask(sweep_mask)
  );

  chk_busy_write_slverr: assert property (@(posedge i_mclk) disable iff (i_rst)
    take_wr && bg_busy |=> o_reg_ack && o_reg_resp == RESP_SLVERR)
    else $error("write during background task not refused");
  chk_atomic_stall_start: assert property (@(posedge i_mclk) disable iff (i_rst)
    take_wr && !bg_busy && is_atomic(i_reg_addr) |=> o_stall && !o_reg_ack)
    else $error("atomic operation did not stall");
  chk_stall_release_ack: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(o_stall) |-> o_reg_ack && o_reg_resp == RESP_OKAY)
    else $error("stall dropped without completion ack");
  chk_sync_holds_open: assert property (@(posedge i_mclk) disable iff (i_rst)
    state == ST_SYNC && !sync_done |=> state == ST_SYNC && o_drain_store_buffer && o_stall)
    else $error("sync ended with buffers not empty");
  chk_busy_flag_read: assert property (@(posedge i_mclk) disable iff (i_rst)
    take && !i_reg_write && is_atomic(i_reg_addr) |=> o_reg_rdata == {31'h0, $past(bg_busy)})
    else $error("atomic register read lost busy flag");
  chk_alloc_lock_mask: assert property (@(posedge i_mclk) disable iff (i_rst)
    sweep_start |-> ##2 o_alloc_lock == $past(sweep_start_mask, 2))
    else $error("targeted ways not locked against allocation");
  chk_writeback_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_wb_valid && !i_wb_ready |=> o_wb_valid && $stable(o_wb_addr))
    else $error("write-back request dropped before accept");
  chk_clean_keeps_valid: assert property (@(posedge i_mclk) disable iff (i_rst)
    state == ST_WRBACK && i_wb_ready && cur_op == OP_CLEAN && !i_fill_valid
    |=> valid_q[cur_index][cur_way] && !dirty_q[cur_index][cur_way])
    else $error("clean changed validity or left dirty");
  chk_flush_invalidates: assert property (@(posedge i_mclk) disable iff (i_rst)
    state == ST_WRBACK && i_wb_ready && cur_op == OP_FLUSH && !i_fill_valid
    |=> !valid_q[cur_index][cur_way])
    else $error("flush left line valid");
  chk_inval_no_writeback: assert property (@(posedge i_mclk) disable iff (i_rst)
    state == ST_LOOKUP && cur_op == OP_INVAL |=> !o_wb_valid && state == ST_IDLE)
    else $error("invalidate wrote a line back");
endmodule : l2_cache_maintenance_ops

// >>> tb/wb_memory_model.sv
`timescale 1ns/1ps
module wb_memory_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_valid,
  input wire logic [31:0] i_wb_addr,
  input wire logic [3:0] i_delay,
  output logic o_wb_ready,
  output logic [31:0] o_last_addr,
  output logic [7:0] o_count
);
  logic [3:0] wait_cnt;
  // Slow memory: accepts after i_delay cycles, one-cycle ready pulse
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ready <= 1'b0;
      o_last_addr <= 32'h0000_0000;
      o_count <= 8'h00;
      wait_cnt <= 4'h0;
    end else if (o_wb_ready) begin
      o_wb_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (i_wb_valid) begin
      if (wait_cnt == i_delay) begin
        o_wb_ready <= 1'b1;
        o_last_addr <= i_wb_addr;
        o_count <= o_count + 8'h01;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : wb_memory_model

// >>> tb/l2_cache_maintenance_ops_tb.sv
`timescale 1ns/1ps
`include "l2m_params.svh"
module l2_cache_maintenance_ops_tb;
  import l2m_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_reg_req = 1'b0, i_reg_write = 1'b0, i_reg_secure = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic i_sixteen_way = 1'b1, i_unlock_all_busy = 1'b0, i_fill_valid = 1'b0, i_fill_ns = 1'b0;
  logic i_fill_dirty = 1'b0, i_store_buffer_empty = 1'b1, i_line_read_buffer_empty = 1'b1;
  logic i_line_fill_buffer_empty = 1'b1, i_eviction_buffer_empty = 1'b1;
  logic [2:0] i_fill_index = 3'h0;
  logic [3:0] i_fill_way = 4'h0, wb_delay = 4'h0;
  logic [23:0] i_fill_tag = 24'h00_0000;
  logic o_reg_ack, o_stall, o_wb_valid, o_drain_store_buffer, o_bg_busy, wb_ready;
  logic [1:0] o_reg_resp, resp;
  logic [31:0] o_reg_rdata, o_wb_addr, wb_last, rdata, prev;
  logic [15:0] o_alloc_lock;
  logic [7:0] wb_count, base;
  logic stall_seen = 1'b0;
  int fails = 0, checks = 0, ack_cnt = 0;
  always #12.5 i_mclk = ~i_mclk;
  l2_cache_maintenance_ops u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_req(i_reg_req),
    .i_reg_write(i_reg_write), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_secure(i_reg_secure), .o_reg_ack(o_reg_ack), .o_reg_resp(o_reg_resp),
    .o_reg_rdata(o_reg_rdata), .o_stall(o_stall), .i_sixteen_way(i_sixteen_way),
    .i_unlock_all_busy(i_unlock_all_busy), .i_fill_valid(i_fill_valid), .i_fill_index(i_fill_index),
    .i_fill_way(i_fill_way), .i_fill_tag(i_fill_tag), .i_fill_ns(i_fill_ns), .i_fill_dirty(i_fill_dirty),
    .o_wb_valid(o_wb_valid), .o_wb_addr(o_wb_addr), .i_wb_ready(wb_ready),
    .o_drain_store_buffer(o_drain_store_buffer), .i_store_buffer_empty(i_store_buffer_empty),
    .i_line_read_buffer_empty(i_line_read_buffer_empty), .i_line_fill_buffer_empty(i_line_fill_buffer_empty),
    .i_eviction_buffer_empty(i_eviction_buffer_empty), .o_alloc_lock(o_alloc_lock), .o_bg_busy(o_bg_busy));
  wb_memory_model u_mem (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_valid(o_wb_valid), .i_wb_addr(o_wb_addr),
    .i_delay(wb_delay), .o_wb_ready(wb_ready), .o_last_addr(wb_last), .o_count(wb_count));
  always @(posedge i_mclk) begin
    if (o_stall === 1'b1) stall_seen = 1'b1;
    if (o_reg_ack === 1'b1) ack_cnt++;
  end
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  // Bit 0 of every atomic write stays zero
  task automatic reg_start(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic sec);
    @(posedge i_mclk);
    i_reg_req <= 1'b1;
    i_reg_write <= wr;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_secure <= sec;
  endtask : reg_start
  task automatic reg_wait();
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_reg_ack !== 1'b1 && n < 400);
    rdata = o_reg_rdata;
    resp = o_reg_resp;
    i_reg_req <= 1'b0;
    chk(n < 400, 1, "no acknowledge");
  endtask : reg_wait
  task automatic reg_op(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic sec);
    reg_start(wr, a, d, sec);
    reg_wait();
  endtask : reg_op
  task automatic fill(input logic [2:0] idx, input logic [3:0] way, input logic [23:0] tag, input logic ns,
      input logic dirty);
    @(posedge i_mclk);
    i_fill_valid <= 1'b1;
    i_fill_index <= idx;
    i_fill_way <= way;
    i_fill_tag <= tag;
    i_fill_ns <= ns;
    i_fill_dirty <= dirty;
    @(posedge i_mclk);
    i_fill_valid <= 1'b0;
  endtask : fill
  task automatic line_op(input logic [11:0] a, input logic [31:0] opnd, input logic sec, input logic wb,
      input logic [31:0] wa);
    base = wb_count;
    stall_seen = 1'b0;
    reg_op(1'b1, a, opnd, sec);
    chk(resp, RESP_OKAY, "line op response");
    chk(stall_seen, 1, "no stall during line op");
    chk(wb_count - base, wb, "write-back count");
    if (wb) chk(wb_last, wa, "write-back address");
  endtask : line_op
  // Software polls until every way bit reads zero; base is set by the caller
  task automatic way_poll(input logic [11:0] a, input logic [31:0] m, input logic sec, input logic [7:0] nwb);
    int n;
    prev = m;
    n = 0;
    do begin
      reg_op(1'b0, a, 32'h0000_0000, sec);
      chk(rdata & ~prev, 0, "way bit set again");
      prev = rdata;
      n++;
    end while (rdata[15:0] !== 16'h0000 && n < 200);
    chk(rdata, 0, "way mask never cleared");
    chk(wb_count - base, nwb, "way op write-backs");
  endtask : way_poll
  task automatic way_op(input logic [11:0] a, input logic [31:0] m, input logic sec, input logic [7:0] nwb);
    base = wb_count;
    reg_op(1'b1, a, m, sec);
    chk(resp, RESP_OKAY, "way op response");
    way_poll(a, m, sec, nwb);
  endtask : way_op
  task automatic t_address_ops();
    fill(3'h2, 4'h3, 24'h12_3456, 1'b0, 1'b1);
    line_op(`L2M_OFS_CLEAN_LINE, 32'h1234_565E, 1'b0, 1'b0, 0);
    line_op(`L2M_OFS_CLEAN_LINE, 32'h1234_565E, 1'b1, 1'b1, 32'h1234_5640);
    line_op(`L2M_OFS_CLEAN_LINE, 32'h1234_5640, 1'b1, 1'b0, 0);
    fill(3'h2, 4'h3, 24'h12_3456, 1'b0, 1'b1);
    line_op(`L2M_OFS_FLUSH_LINE, 32'h1234_5648, 1'b1, 1'b1, 32'h1234_5640);
    line_op(`L2M_OFS_CLEAN_LINE, 32'h1234_5640, 1'b1, 1'b0, 0);
    fill(3'h7, 4'h0, 24'hAB_CDEF, 1'b1, 1'b0);
    line_op(`L2M_OFS_CLEAN_LINE, 32'hABCD_EFE0, 1'b0, 1'b0, 0);
    fill(3'h7, 4'h0, 24'hAB_CDEF, 1'b1, 1'b1);
    line_op(`L2M_OFS_INV_LINE, 32'hABCD_EFE0, 1'b0, 1'b0, 0);
    line_op(`L2M_OFS_CLEAN_LINE, 32'hABCD_EFE0, 1'b0, 1'b0, 0);
  endtask : t_address_ops
  task automatic t_set_way();
    fill(3'h5, 4'h9, 24'h55_0001, 1'b0, 1'b1);
    line_op(`L2M_OFS_CLEAN_SETWAY, 32'h9000_00A0, 1'b0, 1'b0, 0);
    line_op(`L2M_OFS_FLUSH_SETWAY, 32'h9000_00A0, 1'b1, 1'b1, 32'h5500_01A0);
    i_sixteen_way <= 1'b0;
    fill(3'h4, 4'h1, 24'h44_0002, 1'b0, 1'b1);
    line_op(`L2M_OFS_CLEAN_SETWAY, 32'h9000_0080, 1'b1, 1'b1, 32'h4400_0280);
    reg_op(1'b1, `L2M_OFS_INV_WAYS, 32'h0000_FF00, 1'b1);
    repeat (3) @(posedge i_mclk);
    chk(o_bg_busy, 0, "upper ways ran in 8-way mode");
    i_sixteen_way <= 1'b1;
  endtask : t_set_way
  task automatic t_sync();
    i_store_buffer_empty <= 1'b0;
    i_line_fill_buffer_empty <= 1'b0;
    reg_start(1'b1, `L2M_OFS_SYNC, 32'h0000_0000, 1'b1);
    base = ack_cnt;
    repeat (6) @(posedge i_mclk);
    chk(ack_cnt - base, 0, "sync ended with busy buffer");
    chk(o_drain_store_buffer, 1, "store buffer not drained");
    chk(o_stall, 1, "sync not stalling");
    i_store_buffer_empty <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk(ack_cnt - base, 0, "sync ended with fill buffer busy");
    i_line_fill_buffer_empty <= 1'b1;
    reg_wait();
    chk(resp, RESP_OKAY, "sync response");
    chk(o_drain_store_buffer, 0, "drain held after sync");
  endtask : t_sync
  task automatic t_background();
    wb_delay <= 4'h2;
    fill(3'h0, 4'h0, 24'hA0_0000, 1'b0, 1'b1);
    fill(3'h3, 4'h1, 24'hB0_0000, 1'b0, 1'b1);
    base = wb_count;
    reg_op(1'b1, `L2M_OFS_FLUSH_WAYS, 32'h0000_0003, 1'b1);
    repeat (2) @(posedge i_mclk);
    chk(o_alloc_lock, 3, "target ways not locked");
    chk(o_bg_busy, 1, "background flag");
    reg_op(1'b1, `L2M_OFS_CLEAN_LINE, 32'hA000_0000, 1'b1);
    chk(resp, RESP_SLVERR, "write during background");
    reg_op(1'b0, `L2M_OFS_SYNC, 32'h0000_0000, 1'b1);
    chk(rdata[0], 1, "busy bit on atomic read");
    way_poll(`L2M_OFS_FLUSH_WAYS, 32'h0000_0003, 1'b1, 8'h02);
    chk(wb_last, 32'hB000_0060, "flush ways address");
    repeat (2) @(posedge i_mclk);
    chk(o_alloc_lock, 0, "ways still locked");
    line_op(`L2M_OFS_CLEAN_LINE, 32'hA000_0000, 1'b1, 1'b0, 0);
    fill(3'h1, 4'h2, 24'hC0_0000, 1'b0, 1'b1);
    way_op(`L2M_OFS_INV_WAYS, 32'h0000_0004, 1'b1, 8'h00);
    line_op(`L2M_OFS_CLEAN_LINE, 32'hC000_0020, 1'b1, 1'b0, 0);
    fill(3'h6, 4'h5, 24'hD0_0000, 1'b1, 1'b1);
    way_op(`L2M_OFS_CLEAN_WAYS, 32'h0000_0020, 1'b0, 8'h01);
    chk(wb_last, 32'hD000_00C0, "clean ways address");
    line_op(`L2M_OFS_CLEAN_LINE, 32'hD000_00C0, 1'b0, 1'b0, 0);
    wb_delay <= 4'h0;
  endtask : t_background
  task automatic t_unlock_and_misc();
    reg_op(1'b1, 12'h100, 32'h0000_0010, 1'b1);
    chk(resp, RESP_OKAY, "unmapped write");
    reg_op(1'b0, 12'h100, 32'h0000_0000, 1'b1);
    chk(rdata, 0, "unmapped read");
    reg_op(1'b0, `L2M_OFS_SYNC, 32'h0000_0000, 1'b1);
    chk(rdata[0], 0, "busy bit when idle");
    i_unlock_all_busy <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk(o_bg_busy, 1, "unlock not background");
    reg_op(1'b1, `L2M_OFS_SYNC, 32'h0000_0000, 1'b1);
    chk(resp, RESP_SLVERR, "write during unlock");
    i_unlock_all_busy <= 1'b0;
  endtask : t_unlock_and_misc
  initial begin
    #(25 * 60000);
    fails++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk({o_stall, o_bg_busy, o_wb_valid, o_reg_ack}, 0, "outputs after reset");
    t_address_ops();
    t_set_way();
    t_sync();
    t_background();
    t_unlock_and_misc();
    close_out();
  end
endmodule : l2_cache_maintenance_ops_tb
